// file: rtl/serial_eeprom_core.sv
// Serial EEPROM instruction decoder, protection and array
`timescale 1ns/1ps
`default_nettype none
`include "serial_eeprom_defs.svh"

// ----------------------------------------
// Word FIFO between serial side and array
// ----------------------------------------
module serial_eeprom_fifo #(
  parameter int WIDTH = `WORD_W,
  parameter int DEPTH = `FIFO_DEPTH
) (
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             flush_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  output logic                  out_valid_o,
  output logic      [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0]      wp_reg;
  logic [AW:0]      rp_reg;
  wire              full;
  wire              empty;
  wire              push;
  wire              pop;

  assign full        = (wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
  assign empty       = (wp_reg == rp_reg);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = store[rp_reg[AW-1:0]];
  assign push        = in_valid_i && !full && !flush_i;
  assign pop         = out_ready_i && !empty && !flush_i;

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      store[wp_reg[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wp_reg <= '0;
      rp_reg <= '0;
    end
    else if (flush_i)
    begin
      wp_reg <= '0;
      rp_reg <= '0;
    end
    else
    begin
      wp_reg <= wp_reg + (AW+1)'(push);
      rp_reg <= rp_reg + (AW+1)'(pop);
    end
  end
endmodule

// ----------------------------------------
// Instruction logic
// ----------------------------------------
module serial_eeprom_core #(
  parameter int PROG_CYCLES = `PROG_CYCLES
) (
  input  wire logic ref_clk_i,
  input  wire logic rst_b_i,
  input  wire logic sel_i,
  input  wire logic sclk_i,
  input  wire logic sdi_i,
  input  wire logic write_allow_i,
  input  wire logic bound_access_i,
  output logic      sdo_o,
  output logic      sdo_oe_o,
  output logic      busy_o,
  output logic      write_en_o,
  output logic      otp_o
);
  localparam int AW = `ADDR_W;
  localparam int DW = `WORD_W;

  // ----------------------------------------
  // Pin synchronisers, three stages
  // ----------------------------------------
  logic [2:0] sel_s;
  logic [2:0] sclk_s;
  logic [2:0] sdi_s;
  logic [2:0] wa_s;
  logic [2:0] pre_s;
  logic       sel_lvl;
  logic       sclk_lvl;
  logic       sdi_lvl;
  logic       wa_lvl;
  logic       pre_lvl;

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sel_s  <= '0;
      sclk_s <= '0;
      sdi_s  <= '0;
      wa_s   <= '0;
      pre_s  <= '0;
    end
    else
    begin
      sel_s  <= {sel_s[1:0], sel_i};
      sclk_s <= {sclk_s[1:0], sclk_i};
      sdi_s  <= {sdi_s[1:0], sdi_i};
      wa_s   <= {wa_s[1:0], write_allow_i};
      pre_s  <= {pre_s[1:0], bound_access_i};
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sel_lvl  <= 1'b0;
      sclk_lvl <= 1'b0;
      sdi_lvl  <= 1'b0;
      wa_lvl   <= 1'b0;
      pre_lvl  <= 1'b0;
    end
    else
    begin
      if (sel_s[1] == sel_s[2])   sel_lvl  <= sel_s[2];
      if (sclk_s[1] == sclk_s[2]) sclk_lvl <= sclk_s[2];
      if (sdi_s[1] == sdi_s[2])   sdi_lvl  <= sdi_s[2];
      if (wa_s[1] == wa_s[2])     wa_lvl   <= wa_s[2];
      if (pre_s[1] == pre_s[2])   pre_lvl  <= pre_s[2];
    end
  end

  wire clk_rise = (sclk_s[1] == sclk_s[2]) && sclk_s[2] && !sclk_lvl && sel_lvl;
  wire sel_fall = (sel_s[1] == sel_s[2]) && !sel_s[2] && sel_lvl;

  // ----------------------------------------
  // State
  // ----------------------------------------
  serial_eeprom_pkg::fsm_t state_reg;
  serial_eeprom_pkg::cmd_t cmd_reg;
  serial_eeprom_pkg::cmd_t cmd_dec;

  logic [DW-1:0] mem [`N_WORDS];
  logic [4:0]    cnt_reg;
  logic [1:0]    opc_reg;
  logic [AW-1:0] addr_reg;
  logic [AW-1:0] ptr_reg;
  logic [AW-1:0] wr_addr_reg;
  logic [DW-1:0] data_reg;
  logic [DW-1:0] shout_reg;
  logic [2:0]    nw_reg;
  logic          bad_reg;
  logic          fill_reg;
  logic          rdy_reg;
  logic          wen_reg;
  logic          unlock_reg;
  logic [AW-1:0] bound_reg;
  logic          flag_reg;
  logic          otp_reg;
  logic [23:0]   prog_cnt;
  logic          sdo_reg;
  logic          oe_reg;

  // ----------------------------------------
  // Instruction decode
  // ----------------------------------------
  wire [AW-1:0] addr_full = {addr_reg[AW-2:0], sdi_lvl};
  wire [1:0]    ext       = addr_full[AW-1:AW-2];
  wire          all_one   = &addr_full;
  wire          all_zero  = ~|addr_full;

  assign cmd_dec =
    pre_lvl ?
      ((opc_reg == `OP_READ)  ? serial_eeprom_pkg::bound_read_cmd :
       (opc_reg == `OP_WRITE) ? serial_eeprom_pkg::bound_set_cmd :
       (opc_reg == `OP_PAGE)  ? (all_one ? serial_eeprom_pkg::bound_clear_cmd
                                         : serial_eeprom_pkg::cmd_none) :
       (ext == `EXT_OPEN)     ? serial_eeprom_pkg::bound_unlock_cmd :
       all_zero               ? serial_eeprom_pkg::bound_freeze_cmd :
                                serial_eeprom_pkg::cmd_none) :
      ((opc_reg == `OP_READ)  ? serial_eeprom_pkg::cmd_read :
       (opc_reg == `OP_WRITE) ? serial_eeprom_pkg::cmd_write :
       (opc_reg == `OP_PAGE)  ? serial_eeprom_pkg::page_program_cmd :
       (ext == `EXT_FILL)     ? serial_eeprom_pkg::fill_all_cmd :
       (ext == `EXT_OPEN)     ? serial_eeprom_pkg::write_open_cmd :
       (ext == `EXT_LOCK)     ? serial_eeprom_pkg::write_lock_cmd :
                                serial_eeprom_pkg::cmd_none);

  // ----------------------------------------
  // Protection and write gating
  // ----------------------------------------
  wire [AW-1:0] cur_addr = {addr_reg[AW-1:2], addr_reg[1:0] + nw_reg[1:0]};
  wire prot_hit  = (flag_reg != `FLAG_CLEARED) && (cur_addr >= bound_reg);
  wire wr_ok     = wen_reg && wa_lvl;
  wire bound_ok  = wr_ok && unlock_reg && !otp_reg;
  wire is_fill   = (cmd_reg == serial_eeprom_pkg::fill_all_cmd);
  wire is_page   = (cmd_reg == serial_eeprom_pkg::page_program_cmd);
  wire in_prog   = (state_reg == serial_eeprom_pkg::st_prog);
  wire prog_done = in_prog && (prog_cnt == 24'(PROG_CYCLES - 1));

  // ----------------------------------------
  // Data FIFO
  // ----------------------------------------
  wire          push_w = clk_rise && (state_reg == serial_eeprom_pkg::st_data)
                         && (cnt_reg == `WORD_LAST);
  wire [DW-1:0] word_w = {data_reg[DW-2:0], sdi_lvl};
  wire          fifo_in_ready;
  wire          fifo_out_valid;
  wire [DW-1:0] fifo_out_data;
  wire          pop_w = in_prog && fifo_out_valid;

  serial_eeprom_fifo #(
    .WIDTH (DW),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (ref_clk_i),
    .rst_b_i     (rst_b_i),
    .flush_i     (state_reg == serial_eeprom_pkg::st_idle),
    .in_valid_i  (push_w),
    .in_data_i   (word_w),
    .in_ready_o  (fifo_in_ready),
    .out_valid_o (fifo_out_valid),
    .out_data_o  (fifo_out_data),
    .out_ready_i (in_prog)
  );

  // ----------------------------------------
  // Array, one word per generate entry
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `N_WORDS; gi = gi + 1)
    begin : g_word
      wire we = pop_w && (fill_reg || (wr_addr_reg == AW'(gi)));
      always_ff @(posedge ref_clk_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
          mem[gi] <= '0;
        else if (we)
          mem[gi] <= fifo_out_data;
      end
    end
  endgenerate

  // ----------------------------------------
  // Programming timer
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      prog_cnt <= '0;
    else if (in_prog && !prog_done)
      prog_cnt <= prog_cnt + 24'h000001;
    else
      prog_cnt <= '0;
  end

  // ----------------------------------------
  // Frame sequencer
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_reg   <= serial_eeprom_pkg::st_idle;
      cmd_reg     <= serial_eeprom_pkg::cmd_none;
      cnt_reg     <= '0;
      opc_reg     <= '0;
      addr_reg    <= '0;
      ptr_reg     <= '0;
      wr_addr_reg <= '0;
      data_reg    <= '0;
      shout_reg   <= '0;
      nw_reg      <= '0;
      bad_reg     <= 1'b0;
      fill_reg    <= 1'b0;
      rdy_reg     <= 1'b0;
      wen_reg     <= 1'b0;
      unlock_reg  <= 1'b0;
      bound_reg   <= `BOUND_RST;
      flag_reg    <= `FLAG_CLEARED;
      otp_reg     <= 1'b0;
      sdo_reg     <= 1'b0;
    end
    else
    begin
      if (pop_w)
        wr_addr_reg <= {wr_addr_reg[AW-1:2], wr_addr_reg[1:0] + 2'h1};
      case (state_reg)
        serial_eeprom_pkg::st_idle:
        begin
          sdo_reg <= 1'b1;
          if (!sel_lvl || sel_fall)
            rdy_reg <= 1'b0;
          if (clk_rise && sdi_lvl)
          begin
            rdy_reg   <= 1'b0;
            cnt_reg   <= '0;
            state_reg <= serial_eeprom_pkg::st_opc;
          end
        end
        serial_eeprom_pkg::st_opc:
        begin
          if (sel_fall)
            state_reg <= serial_eeprom_pkg::st_idle;
          else if (clk_rise)
          begin
            opc_reg <= {opc_reg[0], sdi_lvl};
            cnt_reg <= cnt_reg + 5'h01;
            if (cnt_reg == `OPC_LAST)
            begin
              cnt_reg   <= '0;
              state_reg <= serial_eeprom_pkg::st_addr;
            end
          end
        end
        serial_eeprom_pkg::st_addr:
        begin
          if (sel_fall)
            state_reg <= serial_eeprom_pkg::st_idle;
          else if (clk_rise)
          begin
            addr_reg <= addr_full;
            cnt_reg  <= cnt_reg + 5'h01;
            if (cnt_reg == `ADDR_LAST)
            begin
              cnt_reg <= '0;
              cmd_reg <= cmd_dec;
              nw_reg  <= '0;
              bad_reg <= 1'b0;
              ptr_reg <= addr_full + AW'(1);
              sdo_reg <= 1'b0;
              case (cmd_dec)
                serial_eeprom_pkg::cmd_read:
                begin
                  shout_reg <= mem[addr_full];
                  state_reg <= serial_eeprom_pkg::st_read;
                end
                serial_eeprom_pkg::bound_read_cmd:
                begin
                  shout_reg <= {bound_reg, flag_reg, `RDBK_PAD};
                  state_reg <= serial_eeprom_pkg::st_read;
                end
                serial_eeprom_pkg::cmd_write,
                serial_eeprom_pkg::page_program_cmd,
                serial_eeprom_pkg::fill_all_cmd:
                  state_reg <= serial_eeprom_pkg::st_data;
                serial_eeprom_pkg::cmd_none:
                  state_reg <= serial_eeprom_pkg::st_skip;
                default:
                  state_reg <= serial_eeprom_pkg::st_armed;
              endcase
            end
          end
        end
        serial_eeprom_pkg::st_data:
        begin
          if (sel_fall)
            state_reg <= serial_eeprom_pkg::st_idle;
          else if (clk_rise)
          begin
            data_reg <= word_w;
            cnt_reg  <= cnt_reg + 5'h01;
            if (push_w)
            begin
              cnt_reg   <= '0;
              nw_reg    <= nw_reg + 3'h1;
              state_reg <= serial_eeprom_pkg::st_armed;
              if (!fifo_in_ready || (prot_hit && !is_fill))
                bad_reg <= 1'b1;
            end
          end
        end
        serial_eeprom_pkg::st_read:
        begin
          if (sel_fall)
            state_reg <= serial_eeprom_pkg::st_idle;
          else if (clk_rise)
          begin
            sdo_reg <= shout_reg[DW-1];
            cnt_reg <= cnt_reg + 5'h01;
            if (cnt_reg == `WORD_LAST && cmd_reg == serial_eeprom_pkg::cmd_read)
            begin
              cnt_reg   <= '0;
              shout_reg <= mem[ptr_reg];
              ptr_reg   <= ptr_reg + AW'(1);
            end
            else
              shout_reg <= {shout_reg[DW-2:0], 1'b0};
          end
        end
        serial_eeprom_pkg::st_armed:
        begin
          if (clk_rise)
          begin
            state_reg <= (is_page && nw_reg != `PAGE_WORDS) ?
                         serial_eeprom_pkg::st_data : serial_eeprom_pkg::st_skip;
            // This rise already carries the next page word's first bit
            data_reg  <= word_w;
            cnt_reg   <= cnt_reg + 5'h01;
          end
          else if (sel_fall)
          begin
            state_reg <= serial_eeprom_pkg::st_idle;
            fill_reg  <= is_fill;
            wr_addr_reg <= addr_reg;
            case (cmd_reg)
              serial_eeprom_pkg::cmd_write,
              serial_eeprom_pkg::page_program_cmd:
                if (wr_ok && !bad_reg)
                  state_reg <= serial_eeprom_pkg::st_prog;
              serial_eeprom_pkg::fill_all_cmd:
                if (wr_ok && !bad_reg && flag_reg == `FLAG_CLEARED)
                  state_reg <= serial_eeprom_pkg::st_prog;
              serial_eeprom_pkg::write_open_cmd:
                if (wa_lvl)
                  wen_reg <= 1'b1;
              serial_eeprom_pkg::write_lock_cmd:
                wen_reg <= 1'b0;
              serial_eeprom_pkg::bound_unlock_cmd:
                if (wr_ok && !otp_reg)
                  unlock_reg <= 1'b1;
              serial_eeprom_pkg::bound_set_cmd:
                if (bound_ok)
                begin
                  bound_reg  <= addr_reg;
                  flag_reg   <= !`FLAG_CLEARED;
                  unlock_reg <= 1'b0;
                  state_reg  <= serial_eeprom_pkg::st_prog;
                end
              serial_eeprom_pkg::bound_clear_cmd:
                if (bound_ok)
                begin
                  bound_reg  <= `BOUND_RST;
                  flag_reg   <= `FLAG_CLEARED;
                  unlock_reg <= 1'b0;
                  state_reg  <= serial_eeprom_pkg::st_prog;
                end
              serial_eeprom_pkg::bound_freeze_cmd:
                if (bound_ok)
                begin
                  otp_reg    <= 1'b1;
                  unlock_reg <= 1'b0;
                  state_reg  <= serial_eeprom_pkg::st_prog;
                end
              default:
                state_reg <= serial_eeprom_pkg::st_idle;
            endcase
          end
        end
        serial_eeprom_pkg::st_prog:
        begin
          sdo_reg <= 1'b0;
          if (prog_done)
          begin
            sdo_reg   <= 1'b1;
            rdy_reg   <= 1'b1;
            fill_reg  <= 1'b0;
            state_reg <= serial_eeprom_pkg::st_idle;
          end
        end
        default:
        begin
          if (sel_fall || !sel_lvl)
            state_reg <= serial_eeprom_pkg::st_idle;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Output drive
  // ----------------------------------------
  wire oe_next = sel_lvl && !sel_fall &&
                 (in_prog || (state_reg == serial_eeprom_pkg::st_read) ||
                  (state_reg == serial_eeprom_pkg::st_idle && rdy_reg));

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      oe_reg <= 1'b0;
      busy_o <= 1'b0;
    end
    else
    begin
      oe_reg <= oe_next;
      busy_o <= in_prog && !prog_done;
    end
  end

  assign sdo_o      = sdo_reg;
  assign sdo_oe_o   = oe_reg;
  assign write_en_o = wen_reg;
  assign otp_o      = otp_reg;
endmodule
`default_nettype wire

// file: rtl/serial_eeprom_defs.svh
// Constants of the serial EEPROM instruction logic
`ifndef SERIAL_EEPROM_DEFS_SVH
`define SERIAL_EEPROM_DEFS_SVH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define ADDR_W        8
`define WORD_W        16
`define N_WORDS       256
`define PAGE_WORDS    3'h4
`define FIFO_DEPTH    16

// ----------------------------------------
// Frame bit counts
// ----------------------------------------
`define OPC_LAST      5'h01
`define ADDR_LAST     5'h07
`define WORD_LAST     5'h0f

// ----------------------------------------
// Opcodes and extensions
// ----------------------------------------
`define OP_READ       2'h2
`define OP_WRITE      2'h1
`define OP_PAGE       2'h3
`define EXT_FILL      2'h1
`define EXT_OPEN      2'h3
`define EXT_LOCK      2'h0

// ----------------------------------------
// Protection values
// ----------------------------------------
`define BOUND_RST     8'hff
`define FLAG_CLEARED  1'b1
`define RDBK_PAD      7'h00

// ----------------------------------------
// Programming time
// ----------------------------------------
`define CLK_MHZ       25
`define PROG_TIME_US  5000
`define PROG_CYCLES   (`PROG_TIME_US * `CLK_MHZ)

`endif

// file: rtl/serial_eeprom_pkg.sv
// Types of the serial EEPROM instruction logic
`default_nettype none
package serial_eeprom_pkg;

  typedef enum logic [2:0] {
    st_idle,
    st_opc,
    st_addr,
    st_data,
    st_read,
    st_armed,
    st_prog,
    st_skip
  } fsm_t;

  typedef enum logic [3:0] {
    cmd_none,
    cmd_read,
    cmd_write,
    page_program_cmd,
    fill_all_cmd,
    write_open_cmd,
    write_lock_cmd,
    bound_read_cmd,
    bound_set_cmd,
    bound_clear_cmd,
    bound_unlock_cmd,
    bound_freeze_cmd
  } cmd_t;

endpackage
`default_nettype wire

// file: verif/serial_eeprom_core_chk.sv
// Assertion checker for the serial EEPROM instruction logic
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_chk #(
  parameter int PROG_CYCLES = 20
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic sel_i,
  input wire logic sclk_i,
  input wire logic sdo_o,
  input wire logic sdo_oe_o,
  input wire logic busy_o,
  input wire logic write_en_o,
  input wire logic otp_o
);
  int busy_cnt;
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
    if (!rst_b_i)
      busy_cnt <= 0;
    else
      busy_cnt <= busy_o ? busy_cnt + 1 : 0;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  a_reset_quiet: assert property ($rose(rst_b_i) |-> !busy_o && !write_en_o)
    else $error("busy or enabled after reset");
  a_busy_low: assert property (busy_o && $past(busy_o) && sdo_oe_o |-> !sdo_o)
    else $error("ready shown while busy");
  a_deselect_idle: assert property (!sel_i [*6] |-> !sdo_oe_o)
    else $error("output driven while deselected");
  a_commit_deselect: assert property ($rose(busy_o) |-> !$past(sel_i, 3))
    else $error("programming started while selected");
  a_prog_length: assert property ($fell(busy_o) |-> busy_cnt >= PROG_CYCLES - 1 &&
    busy_cnt <= PROG_CYCLES + 1) else $error("programming time wrong");
  a_lock_sticky: assert property (otp_o |=> otp_o) else $error("lock bit lost");
  a_oe_selected: assert property ($rose(sdo_oe_o) |-> sel_i)
    else $error("output enabled while deselected");
  a_sdo_on_rise: assert property (sel_i && $past(sel_i, 6) && $changed(sdo_o) &&
    !busy_o && !$past(busy_o) && !$past(busy_o, 2) |-> $past(sclk_i, 3))
    else $error("sdo moved off rise");
  c_prog: cover property ($fell(busy_o));
  c_lock: cover property ($rose(otp_o));
  c_read: cover property (sdo_oe_o && sdo_o && !busy_o);
endmodule
bind serial_eeprom_core serial_eeprom_chk #(.PROG_CYCLES(PROG_CYCLES)) i_chk (
  .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .sel_i(sel_i), .sclk_i(sclk_i), .sdo_o(sdo_o),
  .sdo_oe_o(sdo_oe_o), .busy_o(busy_o), .write_en_o(write_en_o), .otp_o(otp_o)
);
`default_nettype wire

// file: verif/serial_host.sv
// Host serial bus controller model driving select, clock and data
`timescale 1ns/1ps
`default_nettype none
module serial_host (
  input  wire logic ref_clk_i,
  input  wire logic sdo_i,
  input  wire logic sdo_oe_i,
  output var  logic sel_o,
  output var  logic sclk_o,
  output var  logic sdi_o
);
  initial {sel_o, sclk_o, sdi_o} = 3'b000;
  task automatic open_frame();
    sclk_o = 1'b0;
    sel_o = 1'b1;
    repeat (8) @(negedge ref_clk_i);
  endtask
  task automatic shift(input logic [31:0] v, input int n, output logic [31:0] q);
    q = 32'h0;
    for (int i = n - 1; i >= 0; i--)
    begin
      sdi_o = v[i];
      repeat (8) @(negedge ref_clk_i);
      sclk_o = 1'b1;
      repeat (8) @(negedge ref_clk_i);
      // Undriven line reads inverted
      q = {q[30:0], sdo_oe_i ? sdo_i : ~sdo_i};
      sclk_o = 1'b0;
    end
  endtask
  task automatic close_frame();
    repeat (8) @(negedge ref_clk_i);
    sel_o = 1'b0;
    sdi_o = ~sdi_o;
    repeat (8) @(negedge ref_clk_i);
  endtask
endmodule
`default_nettype wire

// file: verif/testbench.sv
// Self-checking testbench of the serial EEPROM instruction logic
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        ref_clk_i, rst_b_i, sel, sclk, sdi, w_allow, pre, sdo, sdo_oe, busy, wen, otp;
  logic [15:0] mem [256];
  logic [15:0] dq [4];
  logic [7:0]  a;
  logic [31:0] q;
  int          err_count = 0, checks_done = 0, seed = 7409, bound = 255, flag = 1;
  serial_eeprom_core #(.PROG_CYCLES(20)) i_dut (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .sel_i(sel), .sclk_i(sclk), .sdi_i(sdi),
    .write_allow_i(w_allow), .bound_access_i(pre), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
    .busy_o(busy), .write_en_o(wen), .otp_o(otp));
  serial_host i_host (.ref_clk_i(ref_clk_i), .sdo_i(sdo), .sdo_oe_i(sdo_oe), .sel_o(sel),
    .sclk_o(sclk), .sdi_o(sdi));
  initial
  begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cmd(input logic p, input logic [10:0] h, input int nw, input logic eb);
    pre = p;
    i_host.open_frame();
    i_host.shift(32'(h), 11, q);
    for (int i = 0; i < nw; i++) i_host.shift(32'(dq[i]), 16, q);
    i_host.close_frame();
    if (eb !== 1'bx) check(32'(busy), 32'(eb));
    if (eb === 1'b1) i_host.open_frame();
    if (eb === 1'b1) check(32'({sdo_oe, sdo}), 32'h2);
    for (int i = 0; i < 99 && busy; i++) @(negedge ref_clk_i);
    repeat (8) @(negedge ref_clk_i);
    if (eb === 1'b1) check(32'({sdo_oe, sdo}), 32'h3);
    if (eb === 1'b1) i_host.close_frame();
  endtask
  task automatic rd(input logic p, input logic [7:0] ra, input int n);
    pre = p;
    i_host.open_frame();
    i_host.shift(32'({3'b110, ra}), 11, q);
    check(32'(q[0]), 32'h0);
    for (int k = 0; k < n; k++)
    begin
      i_host.shift(32'h0, 16, q);
      check(q, 32'(p ? {bound[7:0], flag[0], 7'h00} : mem[8'(ra + k)]));
    end
    i_host.close_frame();
  endtask
  initial
  begin
    {rst_b_i, w_allow, pre} = 3'b010;
    foreach (mem[i]) mem[i] = 16'h0000;
    foreach (dq[i]) dq[i] = 16'($random(seed));
    repeat (16) @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    check(32'({busy, wen, otp}), 32'h0);
    cmd(0, 11'h510, 1, 0);
    cmd(0, 11'h4c0, 0, 1'bx);
    check(32'(wen), 32'h1);
    w_allow = 1'b0;
    cmd(0, 11'h520, 1, 0);
    w_allow = 1'b1;
    cmd(0, 11'h520, 2, 0);
    repeat (4)
    begin
      a = 8'($random(seed));
      dq[0] = 16'($random(seed));
      mem[a] = dq[0];
      cmd(0, {3'b101, a}, 1, 1);
      rd(0, a, 1);
    end
    for (int i = 0; i < 4; i++) mem[8'hfc + 8'((i + 1) % 4)] = dq[i];
    cmd(0, 11'h7fd, 4, 1);
    rd(0, 8'hfc, 5);
    $display("test array access done");
    cmd(1, 11'h4c0, 0, 1'bx);
    cmd(1, 11'h582, 0, 1);
    bound = 'h82;
    flag = 0;
    rd(1, 8'h00, 1);
    cmd(0, 11'h780, 4, 0);
    cmd(0, 11'h582, 1, 0);
    mem[8'h81] = dq[0];
    cmd(0, 11'h581, 1, 1);
    rd(0, 8'h81, 1);
    cmd(0, 11'h440, 1, 0);
    cmd(1, 11'h4c0, 0, 1'bx);
    cmd(1, 11'h7f0, 0, 0);
    cmd(1, 11'h7ff, 0, 1);
    bound = 255;
    flag = 1;
    rd(1, 8'h00, 1);
    foreach (mem[i]) mem[i] = dq[1];
    dq[0] = dq[1];
    cmd(0, 11'h440, 1, 1);
    rd(0, 8'($random(seed)), 2);
    cmd(1, 11'h4c0, 0, 1'bx);
    cmd(1, 11'h400, 0, 1);
    check(32'(otp), 32'h1);
    cmd(1, 11'h4c0, 0, 1'bx);
    cmd(1, 11'h512, 0, 0);
    rd(1, 8'h00, 1);
    cmd(0, 11'h400, 0, 1'bx);
    check(32'(wen), 32'h0);
    cmd(0, 11'h510, 1, 0);
    $display("test protection done");
    finish_test();
  end
  initial
  begin
    repeat (60000) @(posedge ref_clk_i);
    err_count++;
    finish_test();
  end
endmodule
`default_nettype wire
